// >>> dv/frame_grabber.sv
// Frame grabber model: records every pixel that leaves the correction block.
// Assumes one clock shared with the block and a stream without back-pressure.
`timescale 1ns/1ps
module frame_grabber (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench control
	input wire logic clr,
	// Pixel stream from the block
	input wire logic out_valid,
	input wire pixcorr_pkg::pix_t out_pix
);
	// ****************************************
	// Capture store
	// ****************************************
	pixcorr_pkg::pix_t mem [0:8191]; // Pixels in arrival order
	int n; // Arrivals since last clear

	// Valid stands one cycle only, so sample it at every edge
	always @(posedge aclk) begin
		if (!aresetn || clr) begin
			n <= 0;
		end else if (out_valid) begin
			mem[n] <= out_pix;
			n <= n + 1;
		end
	end
endmodule // frame_grabber

// >>> dv/line_pixel_correct_testgen_test.sv
// Self-checking bench for the pixel correction block.
// Assumes the package and block sources are compiled first; registers over AXI4-Lite.
`timescale 1ns/1ps
module line_pixel_correct_testgen_test;
	// ****************************************
	// Signals
	// ****************************************
	logic aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
	logic in_valid = 1'b0, in_ready, out_valid;
	pixcorr_pkg::pix_t in_pix = '0, out_pix, ex;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, cv;
	logic [1:0] bresp, rresp;
	int fails = 0, compares = 0, k, i, n, len;

	// 50 MHz clock
	always #10 aclk = ~aclk;

	pixel_correct #(.NPIX(4096)) DUT (.aclk(aclk), .aresetn(aresetn), .in_valid(in_valid), .in_pix(in_pix),
		.in_ready(in_ready), .out_valid(out_valid), .out_pix(out_pix), .awvalid(awvalid), .awaddr(awaddr),
		.awready(awready), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wready(wready), .bvalid(bvalid),
		.bresp(bresp), .bready(bready), .arvalid(arvalid), .araddr(araddr), .arready(arready),
		.rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready));
	frame_grabber grab (.aclk(aclk), .aresetn(aresetn), .clr(clr), .out_valid(out_valid), .out_pix(out_pix));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, pixcorr_pkg::RESP_OKAY}, {30'h0, bresp});
	endtask

	// Read and compare the masked word
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("rdata", e, rdata & m);
		chk("rresp", {30'h0, pixcorr_pkg::RESP_OKAY}, {30'h0, rresp});
	endtask

	// One pixel, held until taken; valid stays up for back-to-back use
	task automatic px(input logic [9:0] d, input logic s);
		in_valid <= 1'b1;
		in_pix <= {s, d};
		do @(posedge aclk); while (!in_ready);
	endtask

	// Empty the grabber before a burst
	task automatic clear;
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
	endtask

	// Drop valid and let the slowest path (22 cycles) drain
	task automatic idle;
		in_valid <= 1'b0;
		repeat (30) @(posedge aclk);
	endtask

	// Uniform line starting at position 0
	task automatic line(input logic [9:0] v, input int cnt);
		clear();
		for (int j = 0; j < cnt; j++) px(v, j == 0);
		idle();
	endtask

	// Expected corrected value with uniform references
	function automatic logic [9:0] cor(input int v, input int dk, input int br, input int lv);
		int q;
		if (br <= dk) return v[9:0];
		q = (v > dk) ? (v - dk) * lv * 4 / (br - dk) : 0;
		return (q > 1023) ? 10'h3FF : q[9:0];
	endfunction

	// Four pixels from position 0, each checked against the formula; sh drops low bits in 8-bit format
	task automatic quad(input logic [39:0] ins, input int dk, input int br, input int lv, input int sh);
		clear();
		for (int j = 0; j < 4; j++) px(ins[j*10 +: 10], j == 0);
		idle();
		for (int j = 0; j < 4; j++) begin
			chk("corr", {22'h0, cor(ins[j*10 +: 10], dk, br, lv) >> sh}, {22'h0, grab.mem[j].data});
		end
	endtask

	// Shared end of run
	task automatic results;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog, nearly three times the expected run
	initial begin
		repeat (70000) @(posedge aclk);
		fails++;
		results();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(pixcorr_pkg::A_CTRL, 32'h0000001F, 32'h00000010);
		rdc(pixcorr_pkg::A_LEVEL, 32'h000000FF, 32'h000000C8);
		// Factory references straight after reset
		quad({10'h3FF, 10'h2BC, 10'h001, 10'h200}, 0, 1023, 200, 0);
		wr(pixcorr_pkg::A_LEVEL, 32'h000000FF);
		quad({10'h3FF, 10'h2BC, 10'h001, 10'h200}, 0, 1023, 255, 0);
		// Ramp in all four format and width combinations
		for (k = 0; k < 4; k++) begin
			cv = (k == 0) ? 32'h11 : (k == 1) ? 32'h15 : (k == 2) ? 32'h13 : 32'h17;
			len = cv[2] ? 2048 : 4096;
			n = len + 1;
			wr(pixcorr_pkg::A_CTRL, cv);
			line(10'h155, n);
			for (i = 0; i < n; i++) begin
				ex.sol = (i % len == 0);
				ex.data = cv[1] ? {2'h0, i[9:2]} : i[9:0];
				chk("ramp", {21'h0, ex}, {21'h0, grab.mem[i]});
			end
		end
		// One pixel past a 2048 line: next position is 1
		rdc(pixcorr_pkg::A_STAT, 32'h0FFF0000, 32'h00010000);
		// User bright capture, then dark capture, both uniform lines
		wr(pixcorr_pkg::A_CTRL, 32'h00000008);
		wr(pixcorr_pkg::A_CMD, 32'h00000001);
		rdc(pixcorr_pkg::A_CMD, 32'h00000003, 32'h00000001);
		line(10'h100, 4096);
		rdc(pixcorr_pkg::A_STAT, 32'h00000005, 32'h00000004);
		rdc(pixcorr_pkg::A_CMD, 32'h00000003, 32'h00000000);
		wr(pixcorr_pkg::A_CMD, 32'h00000002);
		line(10'h064, 4096);
		rdc(pixcorr_pkg::A_STAT, 32'h0000000A, 32'h00000008);
		wr(pixcorr_pkg::A_CTRL, 32'h00000018);
		wr(pixcorr_pkg::A_LEVEL, 32'h000000C8);
		// Scaled, clamped, and below-dark pixels
		quad({10'h0B2, 10'h032, 10'h200, 10'h080}, 100, 256, 200, 0);
		// Same pixels in 8-bit output format
		wr(pixcorr_pkg::A_CTRL, 32'h0000001A);
		quad({10'h0B2, 10'h032, 10'h200, 10'h080}, 100, 256, 200, 2);
		// Dark above bright: the span is not positive, input passes
		wr(pixcorr_pkg::A_CTRL, 32'h00000008);
		wr(pixcorr_pkg::A_CMD, 32'h00000002);
		line(10'h12C, 4096);
		wr(pixcorr_pkg::A_CTRL, 32'h00000018);
		quad({10'h3FF, 10'h000, 10'h200, 10'h04D}, 300, 256, 200, 0);
		results();
	end
endmodule // line_pixel_correct_testgen_test

// >>> hw/pixel_correct.sv
// Per-pixel shading correction and ramp test pattern for a line-scan output path.
// Assumes the pixel source and register master share aclk; the source honours in_ready.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// R1: Out = (in - dark) * target / (bright - dark)
// R2: Target level is a 10-bit scale factor
// R3: Keep one dark reference per pixel
// R4: Keep one bright reference per pixel
// R5: Bright command captures next line as reference
// R6: 8-bit level setting becomes normalisation target
// R7: Factory references active straight after reset
// R8: 10-bit ramp wraps at 1023, four per 4096
// R9: Same ramp appears twice on 2048 line
// R10: 8-bit ramp holds each value four pixels
// R11: Clamp, zero negatives, bypass on zero span
module pixel_correct #(
	parameter int NPIX = 4096
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pixel input
	input wire logic in_valid,
	input wire pixcorr_pkg::pix_t in_pix,
	output logic in_ready,
	// Pixel output
	output logic out_valid,
	output pixcorr_pkg::pix_t out_pix,
	// AXI4-Lite write
	input wire logic awvalid,
	input wire logic [pixcorr_pkg::AXI_AW-1:0] awaddr,
	output logic awready,
	input wire logic wvalid,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic wready,
	output logic bvalid,
	output logic [1:0] bresp,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic arvalid,
	input wire logic [pixcorr_pkg::AXI_AW-1:0] araddr,
	output logic arready,
	output logic rvalid,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rready
);
	localparam int PW = pixcorr_pkg::PIX_W;
	localparam int IW = $clog2(NPIX);
	localparam int AW = pixcorr_pkg::AXI_AW;
	localparam logic [IW-1:0] LAST_FULL = IW'(NPIX - 1);
	localparam logic [IW-1:0] LAST_HALF = IW'(NPIX / 2 - 1);

	typedef enum logic [1:0] {
		S_IDLE = 2'b01,  // Ready for a pixel
		S_DIV = 2'b10    // Waiting on the divider
	} pstate_t;

	typedef struct packed {
		logic [NPIX-1:0][PW-1:0] dark;   // Dark reference per pixel
		logic [NPIX-1:0][PW-1:0] bright; // User bright reference per pixel
		pstate_t st;
		logic [IW-1:0] cnt;              // Position of next pixel
		logic [IW-1:0] p;                // Position of pixel in flight
		logic [PW-1:0] vin;              // Raw value in flight
		logic [2*PW-1:0] num;            // Numerator in flight
		logic [PW-1:0] den;              // Span in flight
		logic div_go;                    // Divider start pulse
		logic in_rdy;
		logic out_valid;
		pixcorr_pkg::pix_t out;
		pixcorr_pkg::ctrl_t ctrl;
		logic [pixcorr_pkg::LVL_W-1:0] level;
		logic pend_b, pend_d;            // Capture armed, waits for line start
		logic act_b, act_d;              // Capture running
		logic done_b, done_d;            // A capture has completed
		logic aw_hold, w_hold;
		logic [AW-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} state_t;

	state_t s_r, s_nxt;
	logic div_done;
	logic [2*PW-1:0] quo;
	logic accept, eff_b, eff_d;
	logic [IW-1:0] pos, last;
	logic [PW-1:0] dk, bref, diff, span, tgt, ramp;
	logic [2*PW-1:0] prod;

	// Output format: 8-bit mode drops the two low bits
	function automatic logic [PW-1:0] fmt(input logic [PW-1:0] d, input logic b8);
		fmt = b8 ? (d >> pixcorr_pkg::RAMP8_SHIFT) : d;
	endfunction

	// Register hit: decode shared by read and write paths
	function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
		hit = (a == off);
	endfunction

	// ****************************************
	// Divider
	// ****************************************
	serial_div #(.NW(2 * PW), .DW(PW)) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(s_r.div_go),
		.num(s_r.num),
		.den(s_r.den),
		.done(div_done),
		.quo(quo)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.out_valid = 1'b0;
		s_nxt.div_go = 1'b0;
		accept = in_valid && s_r.in_rdy;
		pos = in_pix.sol ? '0 : s_r.cnt;
		last = s_r.ctrl.half ? LAST_HALF : LAST_FULL; // [R9]
		dk = s_r.dark[pos]; // [R3]
		// Factory bright until software selects its own capture
		bref = s_r.ctrl.user_sel ? s_r.bright[pos] : pixcorr_pkg::FACT_BRIGHT; // [R4] [R7]
		diff = (in_pix.data > dk) ? in_pix.data - dk : '0; // [R11]
		span = (bref > dk) ? bref - dk : '0; // [R11]
		tgt = PW'(s_r.level) << pixcorr_pkg::LVL_SHIFT; // [R2] [R6]
		prod = diff * tgt; // [R1]
		// Ramp from pixel position; the low bits wrap by themselves
		ramp = s_r.ctrl.b8 ? PW'(pos[PW-1:pixcorr_pkg::RAMP8_SHIFT]) : pos[PW-1:0]; // [R8] [R10]
		eff_b = s_r.act_b || (in_pix.sol && s_r.pend_b);
		eff_d = s_r.act_d || (in_pix.sol && s_r.pend_d);

		unique case (s_r.st)
			S_IDLE: begin
				if (accept) begin
					s_nxt.cnt = (pos == last) ? '0 : pos + 1'b1; // [R8] [R9]
					s_nxt.p = pos;
					s_nxt.vin = in_pix.data;
					// Capture raw values of one whole line
					if (in_pix.sol && s_r.pend_b) begin
						s_nxt.pend_b = 1'b0;
					end
					if (in_pix.sol && s_r.pend_d) begin
						s_nxt.pend_d = 1'b0;
					end
					if (eff_b) begin
						s_nxt.bright[pos] = in_pix.data; // [R5]
						s_nxt.act_b = (pos != last);
						s_nxt.done_b = s_r.done_b || (pos == last);
					end
					if (eff_d) begin
						s_nxt.dark[pos] = in_pix.data; // [R3]
						s_nxt.act_d = (pos != last);
						s_nxt.done_d = s_r.done_d || (pos == last);
					end
					s_nxt.out.sol = (pos == '0);
					if (s_r.ctrl.test) begin
						s_nxt.out.data = ramp; // [R8] [R9] [R10]
						s_nxt.out_valid = 1'b1;
					end else if (!s_r.ctrl.corr_en || span == '0) begin
						// Zero span would divide by zero: pass the input
						s_nxt.out.data = fmt(in_pix.data, s_r.ctrl.b8); // [R11]
						s_nxt.out_valid = 1'b1;
					end else begin
						s_nxt.num = prod; // [R1]
						s_nxt.den = span;
						s_nxt.div_go = 1'b1;
						s_nxt.st = S_DIV;
					end
				end
			end
			S_DIV: begin
				if (div_done) begin
					// Clamp before formatting
					s_nxt.out.data = fmt((quo > 20'(pixcorr_pkg::PIX_MAX)) ? pixcorr_pkg::PIX_MAX
						: quo[PW-1:0], s_r.ctrl.b8); // [R1] [R11]
					s_nxt.out_valid = 1'b1;
					s_nxt.st = S_IDLE;
				end
			end
		endcase
		s_nxt.in_rdy = (s_nxt.st == S_IDLE);

		// Write channel: address and data taken in either order
		if (awvalid && s_r.awready) begin
			s_nxt.aw_hold = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_hold = 1'b1;
			s_nxt.w_data = wdata;
			s_nxt.w_strb = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
			s_nxt.aw_hold = 1'b0;
			s_nxt.w_hold = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = pixcorr_pkg::RESP_OKAY;
			if (hit(s_r.aw_addr, pixcorr_pkg::A_CTRL)) begin
				if (s_r.w_strb[0]) begin
					s_nxt.ctrl = s_r.w_data[4:0];
				end
			end else if (hit(s_r.aw_addr, pixcorr_pkg::A_LEVEL)) begin
				if (s_r.w_strb[0]) begin
					s_nxt.level = s_r.w_data[pixcorr_pkg::LVL_W-1:0]; // [R6]
				end
			end else if (hit(s_r.aw_addr, pixcorr_pkg::A_CMD)) begin
				// Arming wins over a same-cycle line-start clear
				if (s_r.w_strb[0] && s_r.w_data[pixcorr_pkg::CMD_BRIGHT]) begin
					s_nxt.pend_b = 1'b1; // [R5]
				end
				if (s_r.w_strb[0] && s_r.w_data[pixcorr_pkg::CMD_DARK]) begin
					s_nxt.pend_d = 1'b1;
				end
			end else if (!hit(s_r.aw_addr, pixcorr_pkg::A_STAT)) begin
				s_nxt.bresp = pixcorr_pkg::RESP_SLVERR;
			end
		end
		s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_hold && !s_nxt.bvalid;

		// Read channel: answer one cycle after the address
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = pixcorr_pkg::RESP_OKAY;
			s_nxt.rdata = '0;
			if (hit(araddr, pixcorr_pkg::A_CTRL)) begin
				s_nxt.rdata = {27'h0000000, s_r.ctrl};
			end else if (hit(araddr, pixcorr_pkg::A_LEVEL)) begin
				s_nxt.rdata = {24'h000000, s_r.level};
			end else if (hit(araddr, pixcorr_pkg::A_CMD)) begin
				s_nxt.rdata = {30'h00000000, s_r.pend_d, s_r.pend_b};
			end else if (hit(araddr, pixcorr_pkg::A_STAT)) begin
				s_nxt.rdata = {4'h0, 12'(s_r.cnt), 12'h000, s_r.done_d, s_r.done_b, s_r.act_d, s_r.act_b};
			end else begin
				s_nxt.rresp = pixcorr_pkg::RESP_SLVERR;
			end
		end
		s_nxt.arready = !s_nxt.rvalid;
	end

	// ****************************************
	// State register
	// ****************************************
	// Reset loads factory references so correction works at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.dark <= {NPIX{pixcorr_pkg::FACT_DARK}}; // [R7]
			s_r.bright <= {NPIX{pixcorr_pkg::FACT_BRIGHT}}; // [R7]
			s_r.level <= pixcorr_pkg::LEVEL_RST;
			s_r.ctrl.corr_en <= 1'b1;
			s_r.st <= S_IDLE;
			s_r.in_rdy <= 1'b1;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign in_ready = s_r.in_rdy;
	assign out_valid = s_r.out_valid;
	assign out_pix = s_r.out;
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Expected 8-bit ramp value, formed from the position in flight
	logic out_data_8_ok;
	assign out_data_8_ok = out_valid && out_pix.data == PW'(s_r.p[PW-1:pixcorr_pkg::RAMP8_SHIFT]);

	sequence direct_pix;
		accept && (s_r.ctrl.test || !s_r.ctrl.corr_en || span == '0);
	endsequence

	quotient_exact_a: assert property (div_done && s_r.st == S_DIV |-> // [R1]
		(30'(quo) * 30'(s_r.den) <= 30'(s_r.num)) && (30'(s_r.num) < (30'(quo) + 30'h1) * 30'(s_r.den)))
		else $error("quotient does not satisfy division");
	target_map_a: assert property (tgt == {s_r.level, 2'b00} && tgt[1:0] == 2'b00) // [R2] [R6]
		else $error("target not level times four");
	dark_store_a: assert property (accept && eff_d |=> s_r.dark[s_r.p] == s_r.vin) // [R3]
		else $error("dark reference not stored");
	bright_store_a: assert property (accept && eff_b |=> s_r.bright[s_r.p] == s_r.vin) // [R4] [R5]
		else $error("bright reference not stored");
	factory_src_a: assert property (!s_r.ctrl.user_sel |-> bref == pixcorr_pkg::FACT_BRIGHT) // [R7]
		else $error("factory bright not used");
	ramp10_a: assert property (accept && s_r.ctrl.test && !s_r.ctrl.b8 |=> out_valid && out_pix.data == s_r.p[PW-1:0]) // [R8]
		else $error("10-bit ramp wrong");
	half_wrap_a: assert property (s_r.ctrl.half && accept && pos == LAST_HALF |=> s_r.cnt == '0) // [R9]
		else $error("2048 line did not wrap");
	ramp8_a: assert property (accept && s_r.ctrl.test && s_r.ctrl.b8 |=> out_data_8_ok) // [R10]
		else $error("8-bit ramp wrong");
	pass_zero_a: assert property (direct_pix ##0 (s_r.ctrl.corr_en && !s_r.ctrl.test) |=> // [R11]
		out_valid && out_pix.data == fmt(s_r.vin, s_r.ctrl.b8))
		else $error("zero span not passed through");
	clamp_range_a: assert property (out_valid && !s_r.ctrl.test |-> out_pix.data <= fmt(pixcorr_pkg::PIX_MAX, s_r.ctrl.b8)) // [R11]
		else $error("output above range");
	div_return_a: assert property (accept && !s_r.ctrl.test && s_r.ctrl.corr_en && span != '0 |=> // [R1]
		!in_ready ##[1:24] out_valid)
		else $error("corrected pixel not returned");

endmodule // pixel_correct

// >>> hw/serial_div.sv
// Restoring serial divider, one quotient bit per clock.
// Assumes start is a single-cycle pulse issued only while idle.
`timescale 1ns/1ps
module serial_div #(
	parameter int NW = 20,
	parameter int DW = 10
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Operands
	input wire logic start,
	input wire logic [NW-1:0] num,
	input wire logic [DW-1:0] den,
	// Result
	output logic done,
	output logic [NW-1:0] quo
);
	localparam int CW = $clog2(NW + 1);
	localparam int DLAT = NW + 1; // Start edge to done sampled high

	typedef struct packed {
		logic busy;              // Iterating
		logic done;              // Result ready pulse
		logic [CW-1:0] cnt;      // Bits left
		logic [DW:0] rem;        // Partial remainder
		logic [NW-1:0] quo;      // Shifts numerator out, quotient in
		logic [DW-1:0] den;      // Held divisor
	} div_state_t;

	div_state_t s_r, s_nxt;
	logic [DW:0] trial;

	// ****************************************
	// Iteration
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		trial = {s_r.rem[DW-1:0], s_r.quo[NW-1]};
		if (start) begin
			// Load operands
			s_nxt.busy = 1'b1;
			s_nxt.cnt = CW'(NW);
			s_nxt.rem = '0;
			s_nxt.quo = num;
			s_nxt.den = den;
		end else if (s_r.busy) begin
			// Trial subtraction
			if (trial >= {1'b0, s_r.den}) begin
				s_nxt.rem = trial - {1'b0, s_r.den};
				s_nxt.quo = {s_r.quo[NW-2:0], 1'b1};
			end else begin
				s_nxt.rem = trial;
				s_nxt.quo = {s_r.quo[NW-2:0], 1'b0};
			end
			s_nxt.cnt = s_r.cnt - 1'b1;
			if (s_r.cnt == CW'(1)) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;
	assign quo = s_r.quo;

	// Fixed latency lets the caller bound its wait
	div_latency_a: assert property (@(posedge aclk) disable iff (!aresetn) start |-> ##DLAT done) // [R1]
		else $error("divider latency wrong");

endmodule // serial_div

// >>> include/pixcorr_pkg.sv
// Constants, register map and carrier types of the pixel correction block.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register slave.
package pixcorr_pkg;

	// ****************************************
	// Pixel format
	// ****************************************
	localparam int PIX_W = 10;               // Pixel and target width
	localparam int LVL_W = 8;                // Correction level setting width
	localparam int LVL_SHIFT = 2;            // 8-bit level to 10-bit target
	localparam int RAMP8_SHIFT = 2;          // Each 8-bit ramp value spans four pixels
	localparam logic [PIX_W-1:0] PIX_MAX = 10'h3FF;
	localparam logic [LVL_W-1:0] LEVEL_RST = 8'hC8; // Default level, 200
	localparam logic [PIX_W-1:0] FACT_DARK = 10'h000;   // Factory dark reference
	localparam logic [PIX_W-1:0] FACT_BRIGHT = 10'h3FF; // Factory bright reference

	// ****************************************
	// Register map
	// ****************************************
	localparam int AXI_AW = 4;
	localparam logic [AXI_AW-1:0] A_CTRL = 4'h0;  // Mode control
	localparam logic [AXI_AW-1:0] A_LEVEL = 4'h4; // Correction level
	localparam logic [AXI_AW-1:0] A_CMD = 4'h8;   // Capture commands
	localparam logic [AXI_AW-1:0] A_STAT = 4'hC;  // Capture status, pixel position
	localparam int CMD_BRIGHT = 0;
	localparam int CMD_DARK = 1;
	localparam int STAT_POS = 16;            // Pixel position field in status
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register, bit 0 upward: test, b8, half, user_sel, corr_en
	typedef struct packed {
		logic corr_en;   // Correction enabled
		logic user_sel;  // Bright source: user capture, else factory
		logic half;      // 2048-pixel line, else full line
		logic b8;        // 8-bit output format
		logic test;      // Ramp replaces sensor data
	} ctrl_t;

	// Pixel carrier
	typedef struct packed {
		logic sol;                // First pixel of a line
		logic [PIX_W-1:0] data;   // Pixel value
	} pix_t;

endpackage
